// >>> hw/serial_input_polyphase_fir.v
`include "sipf_consts.vh"

module serial_input_polyphase_fir #(
   parameter OUT_W = 18
) (
   input wire clk_sys_i,
   input wire rstn_i,
   input wire [`ADDR_W-1:0] reg_addr_i,
   input wire [15:0] reg_wdata_i,
   input wire reg_wr_i,
   input wire reg_rd_i,
   output reg [15:0] reg_rdata_o,
   output wire [3:0] bit_clock_o,
   output wire [3:0] frame_sync_out_o,
   input wire [3:0] serial_sample_in_i,
   output wire [4*OUT_W-1:0] fir_i_o,
   output wire [4*OUT_W-1:0] fir_q_o,
   output wire [3:0] fir_valid_o
);

   localparam NCH = 4;
   localparam ST_IDLE = 2'b01;
   localparam ST_RUN = 2'b10;

   // scale the accumulated product sum back to output width
   function [OUT_W-1:0] scale_out;
      input signed [36:0] a;
      input [1:0] g;
      reg signed [36:0] s;
      begin
         s = a >>> g;
         scale_out = s[`FRAC_BITS+OUT_W-1:`FRAC_BITS];
      end
   endfunction

   // ----------------------------------------------------------------
   // global registers
   // ----------------------------------------------------------------
   reg [3:0] ch_reset_q;
   reg [3:0] ch_sleep_q;
   wire ext_sel = reg_addr_i[`EXT_SEL_BIT];
   wire [1:0] ch_sel = reg_addr_i[`CH_SEL_HI:`CH_SEL_LO];
   wire [7:0] loc = reg_addr_i[7:0];
   wire [3:0] busy_w;
   wire [3:0] pend_w;
   wire [15:0] ch_rd_w [0:NCH-1];

   always @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ch_reset_q <= `CH_RESET_RST;
         ch_sleep_q <= `CH_SLEEP_RST;
      end else if (reg_wr_i && ext_sel) begin
         if (loc == `REG_CH_RESET) begin
            ch_reset_q <= reg_wdata_i[3:0];
         end
         if (loc == `REG_CH_SLEEP) begin
            ch_sleep_q <= reg_wdata_i[3:0];
         end
      end
   end

   always @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         reg_rdata_o <= 16'h0000;
      end else if (reg_rd_i) begin
         if (ext_sel) begin
            case (loc)
               `REG_CH_RESET: reg_rdata_o <= {12'h000, ch_reset_q};
               `REG_CH_SLEEP: reg_rdata_o <= {12'h000, ch_sleep_q};
               `REG_STATUS: reg_rdata_o <= {8'h00, pend_w, busy_w};
               default: reg_rdata_o <= 16'h0000;
            endcase
         end else begin
            reg_rdata_o <= ch_rd_w[ch_sel];
         end
      end else begin
         reg_rdata_o <= 16'h0000;
      end
   end

   // ----------------------------------------------------------------
   // channels: each slice of a per-channel port serves only its own channel
   // ----------------------------------------------------------------
   genvar c;
   generate
      for (c = 0; c < NCH; c = c + 1) begin : ch
         reg [6:0] len_q;
         reg [3:0] taps_q;
         reg [7:0] sd_q;
         reg [7:0] comb5_q;
         reg [6:0] up_q;
         reg [11:0] comb2_q;
         reg [15:0] coef [0:127];
         reg [15:0] hist_i [0:15];
         reg [15:0] hist_q [0:15];
         reg [15:0] rd;
         wire ch_wr = reg_wr_i && !ext_sel && (ch_sel == c);
         wire chrst = ch_reset_q[c];
         wire sleep = ch_sleep_q[c];
         wire [4:0] div = sd_q[`DIV_HI:`DIV_LO];
         wire [1:0] gsel = sd_q[`SCALE_HI:`SCALE_LO];

         // ------------------------------------------------------------
         // channel configuration
         // ------------------------------------------------------------
         always @(posedge clk_sys_i or negedge rstn_i) begin
            if (!rstn_i) begin
               len_q <= 7'h00;
               taps_q <= 4'h0;
               sd_q <= 8'h00;
               comb5_q <= 8'h00;
               up_q <= 7'h00;
               comb2_q <= 12'h000;
            end else if (ch_wr) begin
               case (loc)
                  `REG_FIR_LEN: len_q <= reg_wdata_i[6:0];
                  `REG_TAPS: taps_q <= reg_wdata_i[3:0];
                  `REG_SCALE_DIV: sd_q <= {reg_wdata_i[7:6], 1'b0, reg_wdata_i[4:0]};
                  `REG_COMB5: comb5_q <= reg_wdata_i[7:0];
                  `REG_UPSAMPLE: up_q <= reg_wdata_i[6:0];
                  `REG_COMB2: comb2_q <= reg_wdata_i[11:0];
                  default: len_q <= len_q;
               endcase
            end
         end

         // coefficient store has no reset, like real ram
         always @(posedge clk_sys_i) begin
            if (ch_wr && loc[7] == `COEF_TAG) begin
               coef[loc[6:0]] <= reg_wdata_i;
            end
         end

         always @* begin
            rd = 16'h0000;
            if (loc[7] == `COEF_TAG) begin
               rd = coef[loc[6:0]];
            end else if (loc[7:5] == `HIST_TAG) begin
               rd = loc[4] ? hist_q[loc[3:0]] : hist_i[loc[3:0]];
            end else begin
               case (loc)
                  `REG_FIR_LEN: rd = {9'h000, len_q};
                  `REG_TAPS: rd = {12'h000, taps_q};
                  `REG_SCALE_DIV: rd = {8'h00, sd_q};
                  `REG_COMB5: rd = {8'h00, comb5_q};
                  `REG_UPSAMPLE: rd = {9'h000, up_q};
                  `REG_COMB2: rd = {4'h0, comb2_q};
                  default: rd = 16'h0000;
               endcase
            end
         end
         assign ch_rd_w[c] = rd;

         // ------------------------------------------------------------
         // bit clock divider
         // ------------------------------------------------------------
         reg [4:0] bdiv_q;
         reg sclk_q;
         wire tick = (bdiv_q == div);
         wire rise = !chrst && tick && !sclk_q;

         // preset to the divisor so the first edge after release toggles
         always @(posedge clk_sys_i or negedge rstn_i) begin
            if (!rstn_i) begin
               bdiv_q <= 5'h00;
               sclk_q <= 1'b0;
            end else if (chrst) begin
               bdiv_q <= div;
               sclk_q <= 1'b0;
            end else if (tick) begin
               bdiv_q <= 5'h00;
               sclk_q <= ~sclk_q;
            end else begin
               bdiv_q <= bdiv_q + 5'h01;
            end
         end
         assign bit_clock_o[c] = sclk_q;

         // ------------------------------------------------------------
         // frame rate accumulator
         // ------------------------------------------------------------
         wire [7:0] up_p1 = {1'b0, up_q} + 8'h01;
         wire [8:0] c5_p1 = {1'b0, comb5_q} + 9'h001;
         wire [12:0] c2_p1 = {1'b0, comb2_q} + 13'h0001;
         wire [29:0] total = up_p1 * c5_p1 * c2_p1;
         wire [5:0] dp1 = {1'b0, div} + 6'h01;
         reg [30:0] facc_q;
         reg fs_q;
         wire [30:0] fsum = facc_q + {24'h000000, dp1, 1'b0};
         wire fire = rise && (fsum >= {1'b0, total});

         // the remainder carries over, so periods dither by one bit clock around the exact rate
         always @(posedge clk_sys_i or negedge rstn_i) begin
            if (!rstn_i) begin
               facc_q <= 31'h00000000;
               fs_q <= 1'b0;
            end else if (chrst) begin
               facc_q <= 31'h00000000;
               fs_q <= 1'b0;
            end else if (rise) begin
               facc_q <= fire ? fsum - {1'b0, total} : fsum;
               fs_q <= fire && !sleep;
            end
         end
         assign frame_sync_out_o[c] = fs_q & ~sleep;

         // ------------------------------------------------------------
         // serial capture
         // ------------------------------------------------------------
         reg sd_s1_q;
         reg sd_s2_q;
         reg [1:0] rise_d_q;
         reg [1:0] fire_d_q;
         reg [5:0] bcnt_q;
         reg [31:0] sh_q;
         reg [31:0] word_q;
         reg wdone_q;
         wire srise = rise_d_q[1];
         wire shift_en = srise && (bcnt_q != 6'h00) && (bcnt_q <= `WORD_BITS);

         // events are delayed by the synchroniser depth so the bit read
         // is the pin level at the bit clock rise
         always @(posedge clk_sys_i or negedge rstn_i) begin
            if (!rstn_i) begin
               sd_s1_q <= 1'b0;
               sd_s2_q <= 1'b0;
               rise_d_q <= 2'b00;
               fire_d_q <= 2'b00;
            end else begin
               sd_s1_q <= serial_sample_in_i[c];
               sd_s2_q <= sd_s1_q;
               rise_d_q <= {rise_d_q[0], rise};
               fire_d_q <= {fire_d_q[0], fire && !sleep};
            end
         end

         always @(posedge clk_sys_i or negedge rstn_i) begin
            if (!rstn_i) begin
               bcnt_q <= 6'h00;
               sh_q <= 32'h00000000;
               word_q <= 32'h00000000;
               wdone_q <= 1'b0;
            end else begin
               wdone_q <= 1'b0;
               if (chrst) begin
                  bcnt_q <= 6'h00;
               end else if (srise && fire_d_q[1]) begin
                  bcnt_q <= `CAPTURE_START;
               end else if (srise && bcnt_q != 6'h00) begin
                  bcnt_q <= bcnt_q - 6'h01;
               end
               if (shift_en && !chrst && !fire_d_q[1]) begin
                  sh_q <= {sh_q[30:0], sd_s2_q};
                  if (bcnt_q == 6'h01) begin
                     word_q <= {sh_q[30:0], sd_s2_q};
                     wdone_q <= 1'b1;
                  end
               end
            end
         end

         // ------------------------------------------------------------
         // polyphase filter
         // ------------------------------------------------------------
         reg [1:0] st_q;
         reg pend_q;
         reg [3:0] wp_q;
         reg [3:0] k_q;
         reg [6:0] ci_q;
         reg signed [36:0] acc_i_q;
         reg signed [36:0] acc_q_q;
         reg [OUT_W-1:0] out_i_q;
         reg [OUT_W-1:0] out_q_q;
         reg ov_q;
         wire start = st_q[0] && pend_q;
         wire [3:0] xi = wp_q - 4'h1 - k_q;
         wire signed [31:0] pi = $signed(coef[ci_q]) * $signed(hist_i[xi]);
         wire signed [31:0] pq = $signed(coef[ci_q]) * $signed(hist_q[xi]);
         wire signed [36:0] sum_i = acc_i_q + {{5{pi[31]}}, pi};
         wire signed [36:0] sum_q = acc_q_q + {{5{pq[31]}}, pq};

         // history has no reset; a new sample wins over a software write
         always @(posedge clk_sys_i) begin
            if (start) begin
               hist_i[wp_q] <= word_q[31:16];
               hist_q[wp_q] <= word_q[15:0];
            end else if (ch_wr && loc[7:5] == `HIST_TAG) begin
               if (loc[4]) begin
                  hist_q[loc[3:0]] <= reg_wdata_i;
               end else begin
                  hist_i[loc[3:0]] <= reg_wdata_i;
               end
            end
         end

         always @(posedge clk_sys_i or negedge rstn_i) begin
            if (!rstn_i) begin
               pend_q <= 1'b0;
            end else if (chrst) begin
               pend_q <= 1'b0;
            end else begin
               pend_q <= wdone_q | (pend_q & ~start);
            end
         end

         // one tap per cycle, walking the store phase after phase
         always @(posedge clk_sys_i or negedge rstn_i) begin
            if (!rstn_i) begin
               st_q <= ST_IDLE;
               wp_q <= 4'h0;
               k_q <= 4'h0;
               ci_q <= 7'h00;
               acc_i_q <= 37'h0000000000;
               acc_q_q <= 37'h0000000000;
               out_i_q <= {OUT_W{1'b0}};
               out_q_q <= {OUT_W{1'b0}};
               ov_q <= 1'b0;
            end else begin
               ov_q <= 1'b0;
               if (chrst) begin
                  st_q <= ST_IDLE;
                  wp_q <= 4'h0;
               end else begin
                  case (st_q)
                     ST_IDLE: begin
                        if (pend_q) begin
                           wp_q <= wp_q + 4'h1;
                           k_q <= 4'h0;
                           ci_q <= 7'h00;
                           acc_i_q <= 37'h0000000000;
                           acc_q_q <= 37'h0000000000;
                           st_q <= ST_RUN;
                        end
                     end
                     ST_RUN: begin
                        ci_q <= ci_q + 7'h01;
                        if (k_q == taps_q) begin
                           out_i_q <= scale_out(sum_i, gsel);
                           out_q_q <= scale_out(sum_q, gsel);
                           ov_q <= 1'b1;
                           acc_i_q <= 37'h0000000000;
                           acc_q_q <= 37'h0000000000;
                           k_q <= 4'h0;
                           if (ci_q == len_q) begin
                              st_q <= ST_IDLE;
                           end
                        end else begin
                           acc_i_q <= sum_i;
                           acc_q_q <= sum_q;
                           k_q <= k_q + 4'h1;
                        end
                     end
                     default: st_q <= ST_IDLE;
                  endcase
               end
            end
         end

         assign busy_w[c] = st_q[1];
         assign pend_w[c] = pend_q;
         assign fir_i_o[c*OUT_W +: OUT_W] = out_i_q;
         assign fir_q_o[c*OUT_W +: OUT_W] = out_q_q;
         assign fir_valid_o[c] = ov_q;
      end
   endgenerate

endmodule // serial_input_polyphase_fir

// >>> hw/sipf_consts.vh
`ifndef SIPF_CONSTS_VH
`define SIPF_CONSTS_VH

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define ADDR_W 11
`define EXT_SEL_BIT 10
`define CH_SEL_HI 9
`define CH_SEL_LO 8
`define REG_CH_RESET 8'h04
`define REG_CH_SLEEP 8'h05
`define REG_STATUS 8'h06
`define REG_COMB5 8'h09
`define REG_FIR_LEN 8'h0a
`define REG_TAPS 8'h0c
`define REG_SCALE_DIV 8'h0d
`define REG_UPSAMPLE 8'h12
`define REG_COMB2 8'h13
`define HIST_TAG 3'h1
`define COEF_TAG 1'h1

// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define DIV_HI 4
`define DIV_LO 0
`define SCALE_HI 7
`define SCALE_LO 6
`define CH_RESET_RST 4'hf
`define CH_SLEEP_RST 4'h0

// ----------------------------------------------------------------
// serial word timing and product fraction bits
// ----------------------------------------------------------------
`define WORD_BITS 6'h20
`define CAPTURE_START 6'h21
`define FRAC_BITS 15

`endif

// >>> verification/sipf_checker_assertions.sv
`include "sipf_consts.vh"

module sipf_checker #(
   parameter OUT_W = 18
) (
   input wire clk_sys_i,
   input wire rstn_i,
   input wire [`ADDR_W-1:0] reg_addr_i,
   input wire [15:0] reg_wdata_i,
   input wire reg_wr_i,
   input wire reg_rd_i,
   input wire [15:0] reg_rdata_o,
   input wire [3:0] bit_clock_o,
   input wire [3:0] frame_sync_out_o,
   input wire [3:0] serial_sample_in_i,
   input wire [4*OUT_W-1:0] fir_i_o,
   input wire [4*OUT_W-1:0] fir_q_o,
   input wire [3:0] fir_valid_o
);
   // ---------------------------------------------------------------
   // shadow of control bits, seen from the register writes
   // ---------------------------------------------------------------
   logic [3:0] rst_q;
   logic [3:0] slp_q;
   logic [4:0] div_q;
   logic bc_q;
   logic seen_q;
   logic [5:0] run_q;
   wire tog = bit_clock_o[0] ^ bc_q;
   wire wr_cfg = reg_wr_i && (reg_addr_i == 11'h404 || reg_addr_i == 11'h00d);

   // the half-period count is trusted only after a first toggle, so a
   // divisor change or channel reset never judges a half-finished level
   always @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rst_q <= `CH_RESET_RST;
         slp_q <= `CH_SLEEP_RST;
         div_q <= 5'h00;
         bc_q <= 1'b0;
         run_q <= 6'h00;
         seen_q <= 1'b0;
      end else begin
         if (reg_wr_i && reg_addr_i == 11'h404) rst_q <= reg_wdata_i[3:0];
         if (reg_wr_i && reg_addr_i == 11'h405) slp_q <= reg_wdata_i[3:0];
         if (reg_wr_i && reg_addr_i == 11'h00d) div_q <= reg_wdata_i[4:0];
         bc_q <= bit_clock_o[0];
         run_q <= tog ? 6'h00 : run_q + 6'h01;
         seen_q <= (wr_cfg || rst_q[0]) ? 1'b0 : (seen_q | tog);
      end
   end

   // ---------------------------------------------------------------
   // properties
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (!rstn_i);

   a_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 16'h0000)
      else $error("read data not zero outside read cycle");
   a_bclk_reset_low: assert property ((rst_q & $past(rst_q) & bit_clock_o) == 4'h0)
      else $error("bit clock moves in channel reset");
   a_bclk_start: assert property ($fell(rst_q[0]) |-> ##[0:2] bit_clock_o[0])
      else $error("bit clock late after reset release");
   a_bclk_half: assert property (seen_q && tog |-> run_q == {1'b0, div_q})
      else $error("bit clock half period wrong");
   a_fs_rise_align: assert property (
      $rose(frame_sync_out_o[0]) && !$past(slp_q[0]) |-> $rose(bit_clock_o[0]))
      else $error("frame sync rise off bit clock rise");
   a_fs_fall_align: assert property (
      // a channel reset may cut the pulse off the bit clock grid
      $fell(frame_sync_out_o[0]) && !slp_q[0] && !rst_q[0] |-> $rose(bit_clock_o[0]))
      else $error("frame sync fall off bit clock rise");
   a_fs_sleep_low: assert property (slp_q[0] && $past(slp_q[0]) |-> !frame_sync_out_o[0])
      else $error("frame sync during sleep");
   a_fs_reset_low: assert property (rst_q[0] && $past(rst_q[0]) |-> !frame_sync_out_o[0])
      else $error("frame sync during channel reset");
   a_fir_hold: assert property (
      !fir_valid_o[0] |-> $stable(fir_i_o[OUT_W-1:0]) && $stable(fir_q_o[OUT_W-1:0]))
      else $error("filter output moved without valid");

   c_frame: cover property ($rose(frame_sync_out_o[0]));
   c_valid: cover property (fir_valid_o[0]);
   c_read: cover property (reg_rd_i ##1 reg_rdata_o != 16'h0000);
endmodule // sipf_checker

// >>> verification/dsp_serial_source.sv
module dsp_serial_source (
   input wire clk_sys_i,
   input wire bit_clock_i,
   input wire frame_sync_i,
   input wire [31:0] word_i,
   output logic sample_o = 1'b0
);
   timeunit 1ns;
   timeprecision 1ps;
   logic bc_q = 1'b0;
   logic [5:0] rise_q = 6'h3f;
   logic [31:0] sh_q = 32'h0;

   // ---------------------------------------------------------------
   // sender, paced only by the clocks the device drives
   // ---------------------------------------------------------------
   always @(posedge clk_sys_i) begin
      bc_q <= bit_clock_i;
      if (bit_clock_i && !bc_q) begin
         if (frame_sync_i) begin
            rise_q <= 6'h00;
            sh_q <= word_i;
         end else if (rise_q != 6'h3f) begin
            rise_q <= rise_q + 6'h01;
         end
      end
      // bits change on the low half so they sit still at every rise
      if (!bit_clock_i && bc_q) begin
         if (rise_q >= 6'h01 && rise_q <= 6'h20) begin
            sample_o <= sh_q[31];
            sh_q <= {sh_q[30:0], 1'b0};
         end else begin
            sample_o <= 1'b0;
         end
      end
   end
endmodule // dsp_serial_source

// >>> verification/tb_top.sv
`define CHK(what, exp, got) begin checked++; if ((got) !== (exp)) begin errors++; \
   $display("Error %s expected %0h seen %0h", what, exp, got); end end

module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int OUT_W = 18;
   logic clk_sys_i = 1'b0;
   logic rstn_i = 1'b0;
   logic [10:0] reg_addr_i = 11'h000;
   logic [15:0] reg_wdata_i = 16'h0000;
   logic reg_wr_i = 1'b0;
   logic reg_rd_i = 1'b0;
   logic [31:0] word = 32'h0;
   wire [15:0] reg_rdata_o;
   wire [3:0] bit_clock_o;
   wire [3:0] frame_sync_out_o;
   wire [4*OUT_W-1:0] fir_i_o;
   wire [4*OUT_W-1:0] fir_q_o;
   wire [3:0] fir_valid_o;
   wire sd;
   int errors = 0;
   int checked = 0;
   int cycles = 0;

   always #10 clk_sys_i = ~clk_sys_i;

   serial_input_polyphase_fir #(.OUT_W(OUT_W)) dut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
      .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
      .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .bit_clock_o(bit_clock_o),
      .frame_sync_out_o(frame_sync_out_o), .serial_sample_in_i({3'h0, sd}),
      .fir_i_o(fir_i_o), .fir_q_o(fir_q_o), .fir_valid_o(fir_valid_o));
   dsp_serial_source partner (.clk_sys_i(clk_sys_i), .bit_clock_i(bit_clock_o[0]),
      .frame_sync_i(frame_sync_out_o[0]), .word_i(word), .sample_o(sd));

   // ---------------------------------------------------------------
   // bus and wait helpers
   // ---------------------------------------------------------------
   task automatic wr(input logic [10:0] a, input logic [15:0] d);
      @(posedge clk_sys_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge clk_sys_i);
      reg_wr_i <= 1'b0;
   endtask

   task automatic rdchk(input logic [10:0] a, input logic [15:0] e);
      @(posedge clk_sys_i);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge clk_sys_i);
      reg_rd_i <= 1'b0;
      #1;
      `CHK($sformatf("reg %0h", a), e, reg_rdata_o)
   endtask

   // cycles until the next rising level of frame sync or bit clock
   task automatic rise(input bit fs, output int n);
      logic p;
      logic c;
      n = 0;
      p = fs ? frame_sync_out_o[0] : bit_clock_o[0];
      do begin
         @(posedge clk_sys_i);
         c = fs ? frame_sync_out_o[0] : bit_clock_o[0];
         n++;
         if (c === 1'b1 && p === 1'b0) return;
         p = c;
      end while (n < 2000);
      `CHK("edge wait", 1'b1, 1'b0)
   endtask

   task automatic vwait();
      int n;
      n = 0;
      do begin
         @(posedge clk_sys_i);
         n++;
      end while (fir_valid_o[0] !== 1'b1 && n < 1000);
      if (n >= 1000) `CHK("valid wait", 1'b1, 1'b0)
   endtask

   function automatic logic [OUT_W-1:0] fexp(input logic signed [15:0] c0, c1, x0, x1,
                                             input logic [1:0] g);
      logic signed [36:0] s;
      s = c0 * x0 + c1 * x1;
      s = s >>> g;
      return s[15+OUT_W-1:15];
   endfunction

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_regs();
      rdchk(11'h404, 16'h000f);
      rdchk(11'h405, 16'h0000);
      rdchk(11'h406, 16'h0000);
      wr(11'h00d, 16'h00e3);
      wr(11'h10d, 16'h001f);
      rdchk(11'h00d, 16'h00c3);
      rdchk(11'h10d, 16'h001f);
      rdchk(11'h00e, 16'h0000);
      wr(11'h0ff, 16'ha5a5);
      wr(11'h03f, 16'h5a5a);
      rdchk(11'h0ff, 16'ha5a5);
      rdchk(11'h03f, 16'h5a5a);
      rdchk(11'h07f, 16'h0000);
   endtask

   task automatic t_bclk();
      logic [4:0] dv [3];
      int t;
      dv = '{5'h00, 5'h1f, 5'h03};
      foreach (dv[i]) begin
         wr(11'h404, 16'h000f);
         wr(11'h00d, {11'h000, dv[i]});
         `CHK("clock in reset", 4'h0, bit_clock_o)
         wr(11'h404, 16'h000e);
         rise(1'b0, t);
         `CHK("clock start", 1'b1, t <= 3)
         rise(1'b0, t);
         `CHK("clock period", 2 * (dv[i] + 1), t)
         `CHK("other clocks", 3'h0, bit_clock_o[3:1])
      end
   endtask

   // L = 300 against a bit clock of 8 cycles forces dithered frames
   task automatic t_frames();
      int t0;
      int t1;
      int t2;
      int w;
      wr(11'h404, 16'h000f);
      wr(11'h012, 16'h0000);
      wr(11'h009, 16'h0000);
      wr(11'h013, 16'h012b);
      wr(11'h00d, 16'h0003);
      wr(11'h404, 16'h000e);
      rise(1'b1, t0);
      rise(1'b1, t1);
      rise(1'b1, t2);
      `CHK("first frame", 1'b1, t0 > 280 && t0 < 330)
      `CHK("frame pair", 600, t1 + t2)
      `CHK("frame dither", 1'b1, (t1 == 296 || t1 == 304) && t1 != t2)
      w = 0;
      do begin
         w++;
         @(posedge clk_sys_i);
      end while (frame_sync_out_o[0] === 1'b1 && w < 100);
      `CHK("frame width", 8, w)
      wr(11'h405, 16'h0001);
      w = 0;
      repeat (700) begin
         @(posedge clk_sys_i);
         if (frame_sync_out_o[0] === 1'b1) w++;
      end
      `CHK("frames in sleep", 0, w)
      `CHK("other frames", 3'h0, frame_sync_out_o[3:1])
      wr(11'h405, 16'h0000);
      rise(1'b1, t0);
      `CHK("frames after wake", 1'b1, t0 < 400)
   endtask

   // two phases, two taps each; every coarse scale code in turn
   task automatic t_fir();
      logic [15:0] cf [4];
      logic [31:0] wd [2];
      logic [31:0] prv;
      logic [OUT_W-1:0] ei;
      logic [OUT_W-1:0] eq;
      int t;
      cf = '{16'h4000, 16'hc000, 16'h7fff, 16'h2000};
      wd = '{32'h4000c000, 32'h12348000};
      for (int g = 0; g < 4; g++) begin
         wr(11'h404, 16'h000f);
         for (int i = 0; i < 32; i++) wr(11'(32 + i), 16'h0000);
         for (int i = 0; i < 4; i++) wr(11'(128 + i), cf[i]);
         wr(11'h012, 16'h0001);
         wr(11'h00c, 16'h0001);
         wr(11'h00a, 16'h0003);
         wr(11'h009, 16'h0007);
         wr(11'h013, 16'h0013);
         wr(11'h00d, {8'h00, 2'(g), 6'h03});
         word <= wd[0];
         wr(11'h404, 16'h000e);
         prv = 32'h0;
         for (int n = 0; n < 2; n++) begin
            rise(1'b1, t);
            word <= wd[1];
            for (int p = 0; p < 2; p++) begin
               vwait();
               ei = fexp(cf[2*p], cf[2*p+1], wd[n][31:16], prv[31:16], 2'(g));
               eq = fexp(cf[2*p], cf[2*p+1], wd[n][15:0], prv[15:0], 2'(g));
               `CHK("fir i", ei, fir_i_o[OUT_W-1:0])
               `CHK("fir q", eq, fir_q_o[OUT_W-1:0])
               `CHK("other valid", 3'h0, fir_valid_o[3:1])
            end
            prv = wd[n];
         end
      end
   endtask

   // ---------------------------------------------------------------
   // run control
   // ---------------------------------------------------------------
   task automatic conclude();
      $display("checks %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   initial begin
      repeat (20) @(posedge clk_sys_i);
      rstn_i <= 1'b1;
      @(posedge clk_sys_i);
      t_regs();
      t_bclk();
      t_frames();
      t_fir();
      conclude();
   end

   always @(posedge clk_sys_i) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         conclude();
      end
   end
endmodule // tb_top

bind serial_input_polyphase_fir sipf_checker #(.OUT_W(OUT_W)) u_chk (.clk_sys_i(clk_sys_i),
   .rstn_i(rstn_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
   .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
   .bit_clock_o(bit_clock_o), .frame_sync_out_o(frame_sync_out_o),
   .serial_sample_in_i(serial_sample_in_i), .fir_i_o(fir_i_o), .fir_q_o(fir_q_o),
   .fir_valid_o(fir_valid_o));
